// *** mnsr_pkg.sv ***
// Package for the mesh node status reporter: constants and carrier types.
// Assumes a single 250 MHz clock and synchronous inputs.
package mnsr_pkg;
   localparam int unsigned CLK_MHZ          = 250;
   localparam int unsigned TICK_MS          = 1;
   localparam int unsigned TICK_CYC         = CLK_MHZ * 1000 * TICK_MS;
   localparam int unsigned BASE_UNIT_S      = 10;
   localparam int unsigned MS_PER_S         = 1000;
   localparam logic [7:0]  BASE_DEFAULT     = 8'h06;
   localparam logic [7:0]  BASE_MIN         = 8'h01;
   localparam logic [7:0]  LOC_EN_DEFAULT   = 8'h00;
   localparam logic [7:0]  BLK_SINGLE       = 8'h00;
   localparam logic [7:0]  BLK_FIRST        = 8'h01;
   localparam logic [7:0]  BLK_LAST         = 8'hff;
   localparam logic [7:0]  RSSI_WORST       = 8'hff;
   localparam logic [31:0] NULL_ID          = 32'h0000_0000;
   localparam logic [31:0] GW_ADDR          = 32'h0000_0000;
   localparam logic [7:0]  FWD_ON           = 8'h01;
   localparam int unsigned FIFO_DEPTH       = 4;
   localparam int unsigned FIFO_W           = 8;

   typedef enum logic [1:0] {
      MNSR_ROLE_GATEWAY,
      MNSR_ROLE_ROUTER,
      MNSR_ROLE_END
   } mnsr_role_t;

   typedef enum logic [2:0] {
      MNSR_EV_NONE,
      MNSR_EV_TIMER,
      MNSR_EV_POLL,
      MNSR_EV_INPUT,
      MNSR_EV_JOIN,
      MNSR_EV_TAG
   } mnsr_cause_t;

   typedef struct packed {
      logic [7:0]  din;
      logic [15:0] ain;
      logic [7:0]  temp;
      logic [7:0]  vsup;
   } mnsr_sample_t;

   typedef struct packed {
      mnsr_cause_t  cause;
      logic [31:0]  addr_data;
      mnsr_sample_t sample;
   } mnsr_event_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] src_id;
      logic [7:0]  rssi;
      logic        is_locator;
      logic        neighbour;
      logic        crc_ok;
      logic [7:0]  data;
   } mnsr_rx_t;
endpackage

// *** mnsr_fifo.sv ***
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-high reset.
module mnsr_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 4
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             sys_rst,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Storage
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   // Pointers and count
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// *** mnsr_top.sv ***
// Status reporter of a mesh node: block numbering, locator tracking,
// report timer, join report, tag query and neighbour forwarding.
// Assumes synchronous inputs from the radio and serial-port logic.
module mnsr_top (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 sys_rst,
   // Configuration
   input  wire mnsr_pkg::mnsr_role_t role,
   input  wire logic [7:0]           locator_enable_cfg,
   input  wire logic [7:0]           report_timer_setting,
   input  wire logic [7:0]           report_time_base,
   input  wire logic                 report_on_join_setting,
   input  wire logic [7:0]           neighbour_fwd_cfg,
   input  wire logic                 busy_detect_en,
   input  wire logic                 busy_skip_form,
   // Calibration store for the mesh tag
   input  wire logic                 cal_tag_we,
   input  wire logic [31:0]          cal_tag_wdata,
   input  wire logic                 config_mode,
   input  wire logic                 factory_reset,
   // Event triggers and samples
   input  wire logic                 poll_req,
   input  wire logic                 input_change,
   input  wire logic                 joined,
   input  wire logic                 tag_query,
   input  wire logic [31:0]          tag_query_addr,
   input  wire mnsr_pkg::mnsr_sample_t sample,
   // Serial stream framing
   input  wire logic                 ser_timeout,
   input  wire logic                 ser_buf_full,
   input  wire logic                 ser_flow_stop,
   input  wire logic                 ser_stream_end,
   // Radio side
   input  wire mnsr_pkg::mnsr_rx_t   rx,
   input  wire logic                 channel_busy,
   input  wire logic                 forming_req,
   // Outputs: serial send
   output logic                      ser_send,
   output logic [7:0]                stream_block_index,
   // Outputs: events
   output logic                      event_valid,
   output mnsr_pkg::mnsr_event_t     event_pkt,
   input  wire logic                 event_ack,
   // Outputs: network and locator state
   output logic [31:0]               best_locator_id,
   output logic                      busy_seen,
   output logic                      form_go,
   output logic [31:0]               mesh_instance_tag,
   // Outputs: neighbour forwarding
   output logic                      fwd_valid,
   output logic [7:0]                fwd_data,
   input  wire logic                 fwd_ready,
   output logic                      rx_drop
);
   logic        is_router;
   logic        is_gw;
   logic [7:0]  blk_q;
   logic        in_stream_q;
   logic [7:0]  best_rssi_q;
   logic        loc_seen_q;
   logic [31:0] best_id_q;
   logic [31:0] tag_q;
   logic [27:0] tick_cnt_q;
   logic        tick_ms;
   logic [31:0] base_ms_cnt_q;
   logic [31:0] base_ms;
   logic        base_tick;
   logic [7:0]  period_cnt_q;
   logic        timer_exp;
   logic        joined_q;
   logic        join_rise;
   mnsr_pkg::mnsr_cause_t cause_d;
   logic        ev_pend_q;
   mnsr_pkg::mnsr_event_t ev_q;
   logic        fifo_in_valid;
   logic        fifo_in_ready;
   logic        fifo_out_valid;
   logic [7:0]  fifo_out_data;
   logic        drop_q;
   logic        busy_q;
   logic        form_q;
   logic        send_q;

   // Next block index with wrap past 255
   function automatic logic [7:0] next_blk(input logic [7:0] b);
      next_blk = (b == mnsr_pkg::BLK_LAST) ? mnsr_pkg::BLK_FIRST : b + 8'h01;
   endfunction

   assign is_router = (role == mnsr_pkg::MNSR_ROLE_ROUTER);
   assign is_gw     = (role == mnsr_pkg::MNSR_ROLE_GATEWAY);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         send_q <= 1'b0;
      end else begin
         send_q <= (ser_timeout || ser_buf_full) && !channel_busy;
      end
   end

   // Block index per delivery
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         blk_q       <= mnsr_pkg::BLK_SINGLE;
         in_stream_q <= 1'b0;
      end else if ((ser_timeout || ser_buf_full) && !channel_busy) begin
         if (ser_stream_end) begin
            blk_q       <= in_stream_q ? next_blk(blk_q) : mnsr_pkg::BLK_SINGLE;
            in_stream_q <= 1'b0;
         end else if (ser_flow_stop || in_stream_q) begin
            blk_q       <= in_stream_q ? next_blk(blk_q) : mnsr_pkg::BLK_FIRST;
            in_stream_q <= 1'b1;
         end else begin
            blk_q <= mnsr_pkg::BLK_SINGLE;
         end
      end else if (!in_stream_q && blk_q != mnsr_pkg::BLK_SINGLE) begin
         blk_q <= mnsr_pkg::BLK_SINGLE;
      end
   end

   // Best locator tracking
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         best_id_q   <= mnsr_pkg::NULL_ID;
         best_rssi_q <= mnsr_pkg::RSSI_WORST;
         loc_seen_q  <= 1'b0;
      end else if (rx.valid && rx.crc_ok && rx.is_locator && is_router) begin
         if (!loc_seen_q || rx.rssi <= best_rssi_q) begin
            best_id_q   <= rx.src_id;
            best_rssi_q <= rx.rssi;
            loc_seen_q  <= 1'b1;
         end
      end
   end

   // Mesh tag in calibration store
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tag_q <= mnsr_pkg::NULL_ID;
      end else if (cal_tag_we && config_mode) begin
         tag_q <= cal_tag_wdata;
      end
   end

   // Millisecond tick divider
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tick_cnt_q <= '0;
         tick_ms    <= 1'b0;
      end else begin
         tick_ms <= (tick_cnt_q == 28'(mnsr_pkg::TICK_CYC - 1));
         tick_cnt_q <= (tick_cnt_q == 28'(mnsr_pkg::TICK_CYC - 1))
                       ? '0 : tick_cnt_q + 28'h0000001;
      end
   end

   assign base_ms = 32'(report_time_base < mnsr_pkg::BASE_MIN
                        ? mnsr_pkg::BASE_MIN : report_time_base)
                    * 32'(mnsr_pkg::BASE_UNIT_S * mnsr_pkg::MS_PER_S);
   assign base_tick = tick_ms && (base_ms_cnt_q + 32'h1 >= base_ms);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         base_ms_cnt_q <= '0;
      end else if (tick_ms) begin
         base_ms_cnt_q <= base_tick ? '0 : base_ms_cnt_q + 32'h1;
      end
   end

   // Report period counter
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         period_cnt_q <= '0;
         timer_exp    <= 1'b0;
      end else begin
         timer_exp <= 1'b0;
         if (report_timer_setting == 8'h00) begin
            period_cnt_q <= '0;
         end else if (base_tick) begin
            if (period_cnt_q + 8'h01 >= report_timer_setting) begin
               period_cnt_q <= '0;
               timer_exp    <= 1'b1;
            end else begin
               period_cnt_q <= period_cnt_q + 8'h01;
            end
         end
      end
   end

   // Join edge
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         joined_q <= 1'b0;
      end else begin
         joined_q <= joined;
      end
   end
   assign join_rise = joined && !joined_q;

   // Event cause, input change first
   always_comb begin
      cause_d = mnsr_pkg::MNSR_EV_NONE;
      if (input_change) begin
         cause_d = mnsr_pkg::MNSR_EV_INPUT;
      end else if (tag_query && is_gw && tag_query_addr == mnsr_pkg::GW_ADDR) begin
         cause_d = mnsr_pkg::MNSR_EV_TAG;
      end else if (poll_req) begin
         cause_d = mnsr_pkg::MNSR_EV_POLL;
      end else if (timer_exp) begin
         cause_d = mnsr_pkg::MNSR_EV_TIMER;
      end else if (join_rise && is_router && report_on_join_setting) begin
         cause_d = mnsr_pkg::MNSR_EV_JOIN;
      end
   end

   // Event holding register
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ev_pend_q <= 1'b0;
         ev_q      <= '0;
      end else if (cause_d != mnsr_pkg::MNSR_EV_NONE &&
                   (!ev_pend_q || event_ack)) begin
         ev_pend_q       <= 1'b1;
         ev_q.cause      <= cause_d;
         ev_q.sample     <= sample;
         ev_q.addr_data  <= (cause_d == mnsr_pkg::MNSR_EV_TAG)
                            ? tag_q : best_id_q;
      end else if (event_ack) begin
         ev_pend_q <= 1'b0;
      end
   end

   // Gateway busy detect
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         busy_q <= 1'b0;
         form_q <= 1'b0;
      end else begin
         busy_q <= is_gw && busy_detect_en && (busy_q || channel_busy);
         form_q <= is_gw && forming_req &&
                   !(busy_detect_en && busy_skip_form &&
                     (busy_q || channel_busy));
      end
   end

   assign fifo_in_valid = rx.valid && rx.crc_ok && rx.neighbour && is_router &&
                          neighbour_fwd_cfg == mnsr_pkg::FWD_ON;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         drop_q <= 1'b0;
      end else begin
         drop_q <= rx.valid && rx.neighbour &&
                   (!rx.crc_ok || (fifo_in_valid && !fifo_in_ready));
      end
   end

   mnsr_fifo #(
      .WIDTH (mnsr_pkg::FIFO_W),
      .DEPTH (mnsr_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (rx.data),
      .out_valid (fifo_out_valid),
      .out_ready (fwd_ready && !fwd_valid),
      .out_data  (fifo_out_data)
   );

   // Forward output register
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         fwd_valid <= 1'b0;
         fwd_data  <= '0;
      end else if (fwd_valid) begin
         fwd_valid <= 1'b0;
      end else if (fifo_out_valid && fwd_ready) begin
         fwd_valid <= 1'b1;
         fwd_data  <= fifo_out_data;
      end
   end

   // Registered outputs
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ser_send           <= 1'b0;
         stream_block_index <= mnsr_pkg::BLK_SINGLE;
         event_valid        <= 1'b0;
         event_pkt          <= '0;
         best_locator_id    <= mnsr_pkg::NULL_ID;
         busy_seen          <= 1'b0;
         form_go            <= 1'b0;
         mesh_instance_tag  <= mnsr_pkg::NULL_ID;
         rx_drop            <= 1'b0;
      end else begin
         ser_send           <= send_q;
         stream_block_index <= blk_q;
         event_valid        <= ev_pend_q && !event_ack;
         event_pkt          <= ev_q;
         best_locator_id    <= best_id_q;
         busy_seen          <= busy_q;
         form_go            <= form_q;
         mesh_instance_tag  <= tag_q;
         rx_drop            <= drop_q;
      end
   end
endmodule

// *** mnsr_top_properties.sv ***
// Checker for the status reporter top: send, event and forward timing.
// Bound to every mnsr_top instance; sees only its ports.
module mnsr_top_properties (
   // Clock and reset
   input wire logic                  clk,
   input wire logic                  sys_rst,
   // Inputs watched
   input wire mnsr_pkg::mnsr_role_t  role,
   input wire logic [7:0]            neighbour_fwd_cfg,
   input wire logic                  busy_detect_en,
   input wire logic                  input_change,
   input wire logic                  ser_timeout,
   input wire logic                  ser_buf_full,
   input wire logic                  ser_flow_stop,
   input wire logic                  channel_busy,
   input wire mnsr_pkg::mnsr_rx_t    rx,
   input wire logic                  event_ack,
   // Outputs watched
   input wire logic                  ser_send,
   input wire logic [7:0]            stream_block_index,
   input wire logic                  event_valid,
   input wire mnsr_pkg::mnsr_event_t event_pkt,
   input wire logic [31:0]           best_locator_id,
   input wire logic                  busy_seen,
   input wire logic [31:0]           mesh_instance_tag,
   input wire logic                  fwd_valid,
   input wire logic                  rx_drop
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   a_single_zero: assert property (
      ser_timeout && !ser_buf_full && !ser_flow_stop && !channel_busy |->
      ##2 ser_send && stream_block_index == mnsr_pkg::BLK_SINGLE)
      else $error("single send index not zero");
   a_send_free: assert property (
      ser_send |-> $past((ser_timeout || ser_buf_full) && !channel_busy, 2))
      else $error("send without free request");
   a_stream_nonzero: assert property (
      ser_send && $past(ser_flow_stop, 2) |-> stream_block_index != 8'h00)
      else $error("stream block index zero");
   a_input_event: assert property (
      input_change && !event_valid && !$past(input_change) |->
      ##2 event_valid && event_pkt.cause == mnsr_pkg::MNSR_EV_INPUT)
      else $error("input event not raised");
   a_event_holds: assert property (
      event_valid && !event_ack |=> event_valid && $stable(event_pkt))
      else $error("event dropped before ack");
   a_addr_locator: assert property (
      $rose(event_valid) && event_pkt.cause != mnsr_pkg::MNSR_EV_TAG |->
      event_pkt.addr_data == best_locator_id)
      else $error("event address not best locator");
   a_tag_addr: assert property (
      $rose(event_valid) && event_pkt.cause == mnsr_pkg::MNSR_EV_TAG |->
      event_pkt.addr_data == mesh_instance_tag)
      else $error("tag event without tag");
   a_tag_gateway: assert property (
      event_valid && event_pkt.cause == mnsr_pkg::MNSR_EV_TAG |->
      role == mnsr_pkg::MNSR_ROLE_GATEWAY)
      else $error("tag event from non-gateway");
   a_busy_sticky: assert property (
      busy_seen ##1 (role == mnsr_pkg::MNSR_ROLE_GATEWAY && busy_detect_en)
      |-> busy_seen)
      else $error("busy flag lost");
   a_fwd_spacing: assert property (
      fwd_valid |=> !fwd_valid)
      else $error("forward pulses too close");
   a_crc_drop: assert property (
      rx.valid && !rx.crc_ok && rx.neighbour &&
      role == mnsr_pkg::MNSR_ROLE_ROUTER &&
      neighbour_fwd_cfg == mnsr_pkg::FWD_ON |-> ##2 rx_drop)
      else $error("bad packet not dropped");
endmodule

bind mnsr_top mnsr_top_properties u_props (
   .clk(clk), .sys_rst(sys_rst), .role(role),
   .neighbour_fwd_cfg(neighbour_fwd_cfg), .busy_detect_en(busy_detect_en),
   .input_change(input_change), .ser_timeout(ser_timeout),
   .ser_buf_full(ser_buf_full), .ser_flow_stop(ser_flow_stop),
   .channel_busy(channel_busy), .rx(rx), .event_ack(event_ack),
   .ser_send(ser_send), .stream_block_index(stream_block_index),
   .event_valid(event_valid), .event_pkt(event_pkt),
   .best_locator_id(best_locator_id), .busy_seen(busy_seen),
   .mesh_instance_tag(mesh_instance_tag), .fwd_valid(fwd_valid),
   .rx_drop(rx_drop)
);

// *** mnsr_host_model.sv ***
// Host side model: takes events and forwarded serial bytes.
// Assumes the reporter's clock and reset; can stall both paths.
module mnsr_host_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // Event side
   input  wire logic       event_valid,
   output logic            event_ack,
   input  wire logic       ack_hold,
   // Forward side
   input  wire logic       fwd_valid,
   input  wire logic [7:0] fwd_data,
   output logic            fwd_ready,
   input  wire logic       stall,
   // Received bytes
   output logic [7:0]      got_data,
   output logic [7:0]      got_count
);
   timeunit 1ns;
   timeprecision 1ps;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         event_ack <= 1'b0;
      end else begin
         event_ack <= event_valid && !event_ack && !ack_hold;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         fwd_ready <= 1'b0;
         got_data  <= 8'h00;
         got_count <= 8'h00;
      end else begin
         fwd_ready <= !stall;
         if (fwd_valid && fwd_ready) begin
            got_data  <= fwd_data;
            got_count <= got_count + 8'h01;
         end
      end
   end
endmodule

// *** mnsr_top_test.sv ***
// Testbench for mnsr_top: sequences of port-level requests and checks.
// Assumes the host model on the event and forward outputs.
module mnsr_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [6:0] P_POLL = 7'h40, P_IN = 7'h20, P_TAG = 7'h10;
   localparam logic [6:0] P_TMO = 7'h08, P_FULL = 7'h04, P_WE = 7'h02;
   localparam logic [6:0] P_FR = 7'h01;
   logic clk, sys_rst, report_on_join_setting, busy_detect_en;
   logic busy_skip_form, config_mode, joined, ser_flow_stop;
   logic ser_stream_end, channel_busy, forming_req, ack_hold, stall, ev_q;
   logic poll_req, input_change, tag_query, ser_timeout, ser_buf_full;
   logic cal_tag_we, factory_reset, ser_send, event_valid, event_ack;
   logic busy_seen, form_go, fwd_valid, fwd_ready, rx_drop;
   logic [6:0] pv;
   logic [7:0] neighbour_fwd_cfg, stream_block_index, fwd_data;
   logic [7:0] got_data, got_count;
   logic [31:0] cal_tag_wdata, tag_query_addr, best_locator_id;
   logic [31:0] mesh_instance_tag;
   mnsr_pkg::mnsr_role_t role;
   mnsr_pkg::mnsr_sample_t sample;
   mnsr_pkg::mnsr_rx_t rx;
   mnsr_pkg::mnsr_event_t event_pkt;
   int err_count, n_tests, n_ev, n_send, n_drop, cycles, k;

   assign {poll_req, input_change, tag_query, ser_timeout} = pv[6:3];
   assign {ser_buf_full, cal_tag_we, factory_reset} = pv[2:0];

   mnsr_top DUT (
      .clk(clk), .sys_rst(sys_rst), .role(role),
      .locator_enable_cfg(mnsr_pkg::LOC_EN_DEFAULT),
      .report_timer_setting(8'h00),
      .report_time_base(mnsr_pkg::BASE_DEFAULT),
      .report_on_join_setting(report_on_join_setting),
      .neighbour_fwd_cfg(neighbour_fwd_cfg), .busy_detect_en(busy_detect_en),
      .busy_skip_form(busy_skip_form), .cal_tag_we(cal_tag_we),
      .cal_tag_wdata(cal_tag_wdata), .config_mode(config_mode),
      .factory_reset(factory_reset), .poll_req(poll_req),
      .input_change(input_change), .joined(joined), .tag_query(tag_query),
      .tag_query_addr(tag_query_addr), .sample(sample),
      .ser_timeout(ser_timeout), .ser_buf_full(ser_buf_full),
      .ser_flow_stop(ser_flow_stop), .ser_stream_end(ser_stream_end),
      .rx(rx), .channel_busy(channel_busy), .forming_req(forming_req),
      .ser_send(ser_send), .stream_block_index(stream_block_index),
      .event_valid(event_valid), .event_pkt(event_pkt),
      .event_ack(event_ack), .best_locator_id(best_locator_id),
      .busy_seen(busy_seen), .form_go(form_go),
      .mesh_instance_tag(mesh_instance_tag), .fwd_valid(fwd_valid),
      .fwd_data(fwd_data), .fwd_ready(fwd_ready), .rx_drop(rx_drop)
   );

   mnsr_host_model u_host (
      .clk(clk), .sys_rst(sys_rst), .event_valid(event_valid),
      .event_ack(event_ack), .ack_hold(ack_hold), .fwd_valid(fwd_valid),
      .fwd_data(fwd_data), .fwd_ready(fwd_ready), .stall(stall),
      .got_data(got_data), .got_count(got_count)
   );

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   always @(posedge clk) begin
      ev_q <= event_valid;
      if (event_valid && !ev_q) n_ev++;
      if (ser_send) n_send++;
      if (rx_drop) n_drop++;
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         final_report();
      end
   end

   task final_report;
      $display("Checks %0d, errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [39:0] exp,
         input logic [39:0] got);
      n_tests++;
      if (exp !== got) begin
         err_count++;
         $display("Error %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic pulse(input logic [6:0] m);
      pv = m;
      @(negedge clk);
      pv = 7'h00;
   endtask

   task automatic wait_ev(input logic [2:0] cause, input logic [31:0] addr);
      int i;
      i = 0;
      while (event_valid !== 1'b1 && i < 20) begin
         cyc(1);
         i++;
      end
      chk("event cause", cause, event_pkt.cause);
      chk("event address", addr, event_pkt.addr_data);
      chk("event sample", sample, event_pkt.sample);
      while (event_valid === 1'b1 && i < 60) begin
         cyc(1);
         i++;
      end
      cyc(1);
   endtask

   task automatic quiet(input int n);
      int base;
      base = n_ev;
      cyc(n);
      chk("event count", base, n_ev);
   endtask

   task automatic ser_req(input logic [6:0] m, input logic [7:0] exp);
      int i;
      i = 0;
      pulse(m);
      while (ser_send !== 1'b1 && i < 6) begin
         cyc(1);
         i++;
      end
      chk("block index", exp, stream_block_index);
   endtask

   task automatic send_rx(input logic [31:0] id, input logic [7:0] rssi,
         input logic [2:0] f, input logic [7:0] d);
      rx = '{1'b1, id, rssi, f[2], f[1], f[0], d};
      cyc(1);
   endtask

   initial begin
      {pv, report_on_join_setting, busy_detect_en, busy_skip_form} = '0;
      {config_mode, joined, ser_flow_stop, ser_stream_end} = '0;
      {channel_busy, forming_req, ack_hold, ev_q, rx} = '0;
      {err_count, n_tests, n_ev, n_send, n_drop, cycles} = '0;
      stall = 1'b1;
      neighbour_fwd_cfg = 8'h00;
      cal_tag_wdata = 32'h5a3c_9e17;
      tag_query_addr = mnsr_pkg::GW_ADDR;
      sample = 40'h3c_1234_5678;
      role = mnsr_pkg::MNSR_ROLE_ROUTER;
      sys_rst = 1'b1;
      cyc(5);
      sys_rst = 1'b0;
      chk("best locator", mnsr_pkg::NULL_ID, best_locator_id);
      pulse(P_IN);
      wait_ev(mnsr_pkg::MNSR_EV_INPUT, mnsr_pkg::NULL_ID);
      send_rx(32'h0000_0a01, 8'd50, 3'b101, 8'h00);
      send_rx(32'h0000_0b02, 8'd80, 3'b101, 8'h00);
      send_rx(32'h0000_0c03, 8'd30, 3'b101, 8'h00);
      send_rx(32'h0000_0d04, 8'd10, 3'b001, 8'h00);
      send_rx(32'h0000_0e05, 8'd5, 3'b100, 8'h00);
      send_rx(32'h0000_0f06, 8'd30, 3'b101, 8'h00);
      rx.valid = 1'b0;
      cyc(3);
      chk("best locator", 32'h0000_0f06, best_locator_id);
      ack_hold = 1'b1;
      pulse(P_POLL);
      cyc(8);
      chk("event held", 1'b1, event_valid);
      ack_hold = 1'b0;
      wait_ev(mnsr_pkg::MNSR_EV_POLL, 32'h0000_0f06);
      report_on_join_setting = 1'b1;
      joined = 1'b1;
      wait_ev(mnsr_pkg::MNSR_EV_JOIN, 32'h0000_0f06);
      {joined, report_on_join_setting} = 2'b00;
      cyc(2);
      joined = 1'b1;
      quiet(10);
      joined = 1'b0;
      neighbour_fwd_cfg = mnsr_pkg::FWD_ON;
      for (k = 0; k < 5; k++) send_rx(32'h10 + k, 8'h90, 3'b011, 8'ha0 + k);
      send_rx(32'h20, 8'h90, 3'b010, 8'hee);
      rx.valid = 1'b0;
      cyc(3);
      chk("drop count", 2, n_drop);
      stall = 1'b0;
      cyc(15);
      chk("forward count", 8'h04, got_count);
      chk("forward data", 8'ha3, got_data);
      neighbour_fwd_cfg = 8'h00;
      send_rx(32'h30, 8'h90, 3'b011, 8'h55);
      rx.valid = 1'b0;
      cyc(10);
      chk("forward count", 8'h04, got_count);
      ser_req(P_TMO, mnsr_pkg::BLK_SINGLE);
      channel_busy = 1'b1;
      cyc(1);
      k = n_send;
      pulse(P_TMO);
      cyc(4);
      chk("send count", k, n_send);
      channel_busy = 1'b0;
      ser_flow_stop = 1'b1;
      for (k = 1; k < 258; k++) ser_req(P_FULL, (k > 255) ? k - 255 : k);
      ser_stream_end = 1'b1;
      ser_req(P_FULL, 8'h03);
      {ser_stream_end, ser_flow_stop} = 2'b00;
      cyc(2);
      chk("block index", mnsr_pkg::BLK_SINGLE, stream_block_index);
      ser_req(P_TMO, mnsr_pkg::BLK_SINGLE);
      role = mnsr_pkg::MNSR_ROLE_GATEWAY;
      pulse(P_WE);
      cyc(3);
      chk("tag", 32'h0, mesh_instance_tag);
      config_mode = 1'b1;
      pulse(P_WE);
      cyc(3);
      config_mode = 1'b0;
      chk("tag", 32'h5a3c_9e17, mesh_instance_tag);
      pulse(P_FR);
      cyc(3);
      chk("tag", 32'h5a3c_9e17, mesh_instance_tag);
      pulse(P_TAG);
      wait_ev(mnsr_pkg::MNSR_EV_TAG, 32'h5a3c_9e17);
      tag_query_addr = 32'h0000_0007;
      pulse(P_TAG);
      quiet(10);
      tag_query_addr = mnsr_pkg::GW_ADDR;
      role = mnsr_pkg::MNSR_ROLE_ROUTER;
      pulse(P_TAG);
      quiet(10);
      role = mnsr_pkg::MNSR_ROLE_GATEWAY;
      {busy_detect_en, channel_busy} = 2'b11;
      cyc(1);
      channel_busy = 1'b0;
      cyc(4);
      chk("busy seen", 1'b1, busy_seen);
      {forming_req, busy_skip_form} = 2'b11;
      cyc(3);
      chk("form go", 1'b0, form_go);
      busy_skip_form = 1'b0;
      cyc(3);
      chk("form go", 1'b1, form_go);
      final_report();
   end
endmodule
